// >>> inc/uart_line_pkg.sv
// Constants, register map and carrier types for the serial line controller.
package uart_line_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_TXDATA = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_RXDATA = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_INT_EN = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_INT_CLR = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_HZ = 100000000;
  localparam int BAUD_HZ = 1000000;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] BIT_CYC = CNT_W'(CLK_HZ / BAUD_HZ);
  localparam logic [CNT_W-1:0] HALF_CYC = CNT_W'(CLK_HZ / BAUD_HZ / 2);
  localparam int DATA_BITS = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef struct packed {
    logic [25:0] rsvd;
    logic port_lvl;
    logic port_dir;
    logic par_en;
    logic sync_mode;
    logic re;
    logic te;
  } ctrl_t;
  localparam ctrl_t CTRL_RESET = '0;

  typedef struct packed {
    logic [23:0] rsvd;
    logic txd_level;
    logic tx_busy;
    logic rxd_level;
    logic framing_error_flag;
    logic per;
    logic overrun_error_flag;
    logic rdrf;
    logic transmit_data_empty_flag;
  } stat_t;

  // Receive error flags, in the order the flag cells hold them
  typedef struct packed {
    logic framing_error_flag;
    logic per;
    logic overrun_error_flag;
  } err_t;

  typedef struct packed {
    logic rx_err;
    logic tx_done;
    logic rx_done;
  } evt_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_START = 3'h1,
    TX_DATA = 3'h3,
    TX_PAR = 3'h2,
    TX_STOP = 3'h6
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h3,
    RX_PAR = 3'h2,
    RX_STOP = 3'h6
  } rx_state_t;
endpackage : uart_line_pkg

// >>> rtl/sticky_flags.sv
// Sticky flag bank: hardware sets, software clears, set wins.
`timescale 1ns/1ps
module sticky_flags #(
  parameter int W = 3
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [W-1:0] set, // Hardware set pulses
  input wire logic [W-1:0] clr, // Software clear pulses
  output logic [W-1:0] q // Flag levels
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      // An event in the clearing cycle is kept
      q <= (q & ~clr) | set;
    end
  end
endmodule : sticky_flags

// >>> rtl/uart_line_ctrl.sv
// Serial port with line control, break handling and an AXI4-Lite register slave.
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module uart_line_ctrl (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [uart_line_pkg::ADDR_W-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [uart_line_pkg::ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic rxd_i, // Receive data pin
  input wire logic txd_i, // Transmit pin level read back
  output logic txd_o, // Transmit pin output level
  output logic txd_oe, // Transmit pin output enable
  output logic sck_o, // Serial clock in synchronous mode
  output logic irq // Interrupt, high while an enabled event is pending
);
  import uart_line_pkg::*;

  ctrl_t ctrl_q;
  err_t err_q;
  err_t err_set;
  err_t err_clr;
  evt_t evt;
  evt_t int_st;
  evt_t int_en_q;
  evt_t int_clr;
  stat_t stat;
  tx_state_t tx_state_q;
  rx_state_t rx_state_q;
  logic [CNT_W-1:0] tx_cnt_q;
  logic [CNT_W-1:0] rx_cnt_q;
  logic [2:0] tx_bit_q;
  logic [2:0] rx_bit_q;
  logic [DATA_BITS-1:0] tx_buf_q;
  logic [DATA_BITS-1:0] tx_sh_q;
  logic [DATA_BITS-1:0] rx_sh_q;
  logic [DATA_BITS-1:0] rx_data_q;
  logic tx_par_q;
  logic rx_par_bad_q;
  logic tx_line_q;
  logic transmit_data_empty_flag_q;
  logic rdrf_q;
  logic rxd_q;
  logic txd_in_q;
  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_en;
  logic wr_lo;
  logic rd_take;
  logic tx_start;
  logic tx_bit_end;
  logic rx_bit_end;
  logic rx_frame_end;
  logic rx_store;
  logic rxdata_read;
  logic [31:0] rd_val;
  logic rd_ok;

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order

  assign wr_en = aw_full_q && w_full_q && !bvalid;
  // All fields sit in the low byte, so byte lane 0 gates every write
  assign wr_lo = wr_en && w_strb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awready <= 1'b1;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_full_q <= 1'b1;
      awready <= 1'b0;
      aw_addr_q <= awaddr;
    end else if (bvalid && bready) begin
      aw_full_q <= 1'b0;
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wready <= 1'b1;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && wready) begin
      w_full_q <= 1'b1;
      wready <= 1'b0;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (bvalid && bready) begin
      w_full_q <= 1'b0;
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      case (aw_addr_q)
        ADDR_CTRL, ADDR_STAT, ADDR_TXDATA, ADDR_INT_EN, ADDR_INT_CLR: bresp <= RESP_OKAY;
        default: bresp <= RESP_SLVERR;
      endcase
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  assign rd_take = arvalid && arready;
  assign rxdata_read = rd_take && (araddr == ADDR_RXDATA);

  always_comb begin
    rd_ok = 1'b1;
    case (araddr)
      ADDR_CTRL: rd_val = 32'(ctrl_q);
      ADDR_STAT: rd_val = 32'(stat);
      ADDR_RXDATA: rd_val = 32'(rx_data_q);
      ADDR_INT_STAT: rd_val = 32'(int_st);
      ADDR_INT_EN: rd_val = 32'(int_en_q);
      default: begin
        rd_val = '0;
        rd_ok = (araddr == ADDR_TXDATA) || (araddr == ADDR_INT_CLR);
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (rd_take) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_val;
      rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control, status and interrupt registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
      int_en_q <= '0;
      tx_buf_q <= '0;
    end else if (wr_lo) begin
      if (aw_addr_q == ADDR_CTRL) ctrl_q <= ctrl_t'({26'h0, w_data_q[5:0]});
      if (aw_addr_q == ADDR_INT_EN) int_en_q <= evt_t'(w_data_q[2:0]);
      if (aw_addr_q == ADDR_TXDATA) tx_buf_q <= w_data_q[DATA_BITS-1:0];
    end
  end

  // Pin levels are sampled once so software sees a stable value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_q <= 1'b1;
      txd_in_q <= 1'b1;
    end else begin
      rxd_q <= rxd_i;
      txd_in_q <= txd_i;
    end
  end

  always_comb begin
    stat = '0;
    stat.transmit_data_empty_flag = transmit_data_empty_flag_q;
    stat.rdrf = rdrf_q;
    stat.overrun_error_flag = err_q.overrun_error_flag;
    stat.per = err_q.per;
    stat.framing_error_flag = err_q.framing_error_flag;
    stat.rxd_level = rxd_q;
    stat.tx_busy = (tx_state_q != TX_IDLE);
    stat.txd_level = txd_in_q;
  end

  // Error flags clear only by a one written to the status register
  assign err_clr = (wr_lo && aw_addr_q == ADDR_STAT) ?
                   err_t'(w_data_q[4:2]) : '0;
  assign int_clr = (wr_lo && aw_addr_q == ADDR_INT_CLR) ? evt_t'(w_data_q[2:0]) : '0;

  sticky_flags #(.W(3)) err_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(err_set),
    .clr(err_clr),
    .q(err_q)
  );

  sticky_flags #(.W(3)) int_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(evt),
    .clr(int_clr),
    .q(int_st)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= |(int_st & int_en_q);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmitter

  // Sync mode refuses to start while any receive error is pending
  assign tx_start = ctrl_q.te && !transmit_data_empty_flag_q && (tx_state_q == TX_IDLE) &&
                    !(ctrl_q.sync_mode && (|err_q));
  assign tx_bit_end = (tx_cnt_q == BIT_CYC - 1'b1);

  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl_q.te) begin
      transmit_data_empty_flag_q <= 1'b1;
    end else if (tx_start) begin
      transmit_data_empty_flag_q <= 1'b1;
    end else if (wr_lo && aw_addr_q == ADDR_TXDATA) begin
      transmit_data_empty_flag_q <= 1'b0;
    end
  end

  // Dropping enable aborts any frame in flight, mid-bit included
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl_q.te) begin
      tx_state_q <= TX_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q <= '0;
      tx_par_q <= 1'b0;
      tx_line_q <= 1'b1;
    end else begin
      tx_cnt_q <= (tx_state_q == TX_IDLE || tx_bit_end) ? '0 : tx_cnt_q + 1'b1;
      case (tx_state_q)
        TX_IDLE: begin
          if (tx_start) begin
            tx_sh_q <= tx_buf_q;
            tx_par_q <= ^tx_buf_q;
            tx_bit_q <= '0;
            tx_state_q <= ctrl_q.sync_mode ? TX_DATA : TX_START;
            tx_line_q <= ctrl_q.sync_mode ? tx_buf_q[0] : 1'b0;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_state_q <= TX_DATA;
            tx_line_q <= tx_sh_q[0];
          end
        end
        TX_DATA: begin
          if (tx_bit_end && tx_bit_q != LAST_BIT) begin
            tx_bit_q <= tx_bit_q + 1'b1;
            tx_sh_q <= tx_sh_q >> 1;
            tx_line_q <= tx_sh_q[1];
          end else if (tx_bit_end && ctrl_q.sync_mode) begin
            tx_state_q <= TX_IDLE;
            tx_line_q <= 1'b1;
          end else if (tx_bit_end) begin
            tx_state_q <= ctrl_q.par_en ? TX_PAR : TX_STOP;
            tx_line_q <= ctrl_q.par_en ? tx_par_q : 1'b1;
          end
        end
        TX_PAR: begin
          if (tx_bit_end) begin
            tx_state_q <= TX_STOP;
            tx_line_q <= 1'b1;
          end
        end
        TX_STOP: begin
          if (tx_bit_end) tx_state_q <= TX_IDLE;
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // Pin ownership: transmitter when enabled, otherwise the port bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_o <= 1'b0;
      txd_oe <= 1'b0;
      sck_o <= 1'b1;
    end else begin
      txd_o <= ctrl_q.te ? tx_line_q : ctrl_q.port_lvl;
      txd_oe <= ctrl_q.te ? 1'b1 : ctrl_q.port_dir;
      sck_o <= !(ctrl_q.sync_mode && tx_state_q == TX_DATA && tx_cnt_q < HALF_CYC);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receiver

  assign rx_bit_end = (rx_cnt_q == BIT_CYC - 1'b1);
  assign rx_frame_end = (rx_state_q == RX_STOP) && rx_bit_end;
  assign rx_store = rx_frame_end && !rdrf_q;

  // Starting on a low level, not an edge, keeps a break producing frames
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl_q.re) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_par_bad_q <= 1'b0;
    end else begin
      rx_cnt_q <= (rx_state_q == RX_IDLE || rx_bit_end) ? '0 : rx_cnt_q + 1'b1;
      case (rx_state_q)
        RX_IDLE: begin
          if (!rxd_q) rx_state_q <= RX_START;
          rx_par_bad_q <= 1'b0;
        end
        RX_START: begin
          if (rx_cnt_q == HALF_CYC - 1'b1) begin
            rx_state_q <= rxd_q ? RX_IDLE : RX_DATA;
            rx_bit_q <= '0;
          end
          if (rx_cnt_q == HALF_CYC - 1'b1) begin
            rx_cnt_q <= '0;
          end
        end
        RX_DATA: begin
          if (rx_bit_end) begin
            rx_sh_q <= {rxd_q, rx_sh_q[DATA_BITS-1:1]};
            rx_bit_q <= rx_bit_q + 1'b1;
            if (rx_bit_q == LAST_BIT) rx_state_q <= ctrl_q.par_en ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: begin
          if (rx_bit_end) begin
            rx_par_bad_q <= rxd_q ^ (^rx_sh_q);
            rx_state_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_bit_end) rx_state_q <= RX_IDLE;
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // A low stop bit marks a framing error; a break passes the parity check, as all zeros give even parity
  assign err_set.framing_error_flag = rx_frame_end && !rxd_q;
  assign err_set.per = rx_frame_end && rx_par_bad_q;
  assign err_set.overrun_error_flag = rx_frame_end && rdrf_q;
  assign evt.rx_done = rx_store;
  assign evt.rx_err = |err_set;
  assign evt.tx_done = ctrl_q.te && tx_bit_end &&
                       ((tx_state_q == TX_STOP) || (tx_state_q == TX_DATA &&
                        ctrl_q.sync_mode && tx_bit_q == LAST_BIT));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdrf_q <= 1'b0;
      rx_data_q <= '0;
    end else begin
      rdrf_q <= rx_store | (rdrf_q & !rxdata_read);
      if (rx_store) rx_data_q <= rx_sh_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rxd_level_seen: assert property ($past(rxd_i) == stat.rxd_level)
    else $error("status does not show the receive pin level");
  a_break_sets_fer: assert property (rx_frame_end && !rxd_q |=> err_q.framing_error_flag)
    else $error("low stop bit did not set the framing flag");
  a_break_restarts: assert property (
    rx_state_q == RX_IDLE && ctrl_q.re && !rxd_q |=> rx_state_q == RX_START)
    else $error("receiver did not restart on a low line");
  a_port_drives_pin: assert property (
    !ctrl_q.te |=> txd_oe == $past(ctrl_q.port_dir) && txd_o == $past(ctrl_q.port_lvl))
    else $error("port bits do not control the disabled transmit pin");
  a_te_clear_init: assert property (
    $fell(ctrl_q.te) |=> tx_state_q == TX_IDLE && transmit_data_empty_flag_q && txd_oe == $past(ctrl_q.port_dir))
    else $error("transmitter not reset when enable cleared");
  a_sync_err_block: assert property (
    ctrl_q.sync_mode && (|err_q) && tx_state_q == TX_IDLE |=> tx_state_q == TX_IDLE)
    else $error("transmission started with a receive error pending");
  a_flags_kept: assert property (err_clr == '0 |=> (err_q & $past(err_q)) == $past(err_q))
    else $error("error flag dropped without a software clear");
  a_tx_owns_pin: assert property (ctrl_q.te |=> txd_oe && txd_o == $past(tx_line_q))
    else $error("transmit pin not driven by the transmitter");
endmodule : uart_line_ctrl

// >>> verification/line_partner.sv
// Remote serial station: drives the receive line and decodes the transmit line.
`timescale 1ns/1ps
module line_partner (
  input wire logic aclk, // System clock
  input wire logic txd, // Transmit pin level
  output logic rxd // Receive pin level
);
  localparam int BT = 100;
  initial rxd = 1'b1;
  // Start bit, eight data bits LSB first, then stop at idle level
  task automatic send_byte(input logic [7:0] b);
    for (int i = -1; i < 9; i++) begin
      rxd <= (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : b[i];
      repeat (BT) @(posedge aclk);
    end
  endtask : send_byte
  task automatic hold_break(input int cyc);
    rxd <= 1'b0;
    repeat (cyc) @(posedge aclk);
    rxd <= 1'b1;
  endtask : hold_break
  // Samples mid-bit so one cycle of pin lag does not matter
  task automatic catch_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (txd !== 1'b0 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    ok = (n < 2000);
    repeat (BT + BT / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      b[i] = txd;
      repeat (BT) @(posedge aclk);
    end
  endtask : catch_byte
endmodule : line_partner

// >>> verification/test_serial_port_line_control.sv
// Self-checking bench for the serial line controller.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module test_serial_port_line_control;
  import uart_line_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, txd_o, txd_oe, sck_o, irq, rxd;
  logic [1:0] bresp, rresp, rd_resp;
  logic [31:0] rdata, rd_data;
  wire logic pin;
  int n_errors = 0;
  int comparisons = 0;
  int ctrl_m;
  logic [7:0] tx_q[$];
  // Pull-up holds the pin at mark while nobody drives it
  assign pin = txd_oe ? txd_o : 1'b1;
  initial begin
    forever #5 aclk = ~aclk;
  end
  uart_line_ctrl uart_line_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rxd_i(rxd), .txd_i(pin), .txd_o(txd_o), .txd_oe(txd_oe),
    .sck_o(sck_o), .irq(irq));
  line_partner line_partner_inst (.aclk(aclk), .txd(pin), .rxd(rxd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  task automatic fail_wait(input string nm);
    n_errors++;
    $display("[FAIL] %s expected answer seen timeout", nm);
    test_done();
  endtask : fail_wait
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
      if (n > 50) fail_wait("write");
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
      if (n > 50) fail_wait("read");
    end while (rvalid !== 1'b1);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic setc(input int v);
    ctrl_m = v;
    wr(ADDR_CTRL, 32'(v));
  endtask : setc
  task automatic wait_stat(input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(ADDR_STAT);
      n++;
      if (n > 400) fail_wait("status");
    end while (rd_data[b] !== v);
  endtask : wait_stat
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] b;
    logic [7:0] got;
    logic ok;
    int n;
    void'($urandom(94885));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL);
    `CHK("ctrl reset", 32'h0, rd_data)
    rd(ADDR_STAT);
    `CHK("stat reset", 32'hA1, rd_data)
    rd(8'h40);
    `CHK("unmapped resp", RESP_SLVERR, rd_resp)
    // Every port direction and level with transmit off
    for (int i = 0; i < 4; i++) begin
      setc(i << 4);
      repeat (2) @(posedge aclk);
      #1;
      `CHK("pin drive", i[0], txd_oe)
      if (i[0]) `CHK("pin level", i[1], pin)
    end
    wr(ADDR_INT_EN, 32'h2);
    setc(32'h11);
    repeat (2) @(posedge aclk);
    #1;
    `CHK("idle tx pin", 1'b1, pin)
    b = 8'($urandom);
    tx_q.push_back(b);
    fork
      wr(ADDR_TXDATA, 32'(b));
      line_partner_inst.catch_byte(got, ok);
    join
    `CHK("frame seen", 1'b1, ok)
    `CHK("tx byte", tx_q[0], got)
    void'(tx_q.pop_front());
    repeat (200) @(posedge aclk);
    `CHK("irq raised", 1'b1, irq)
    wr(ADDR_INT_EN, 32'h0);
    repeat (2) @(posedge aclk);
    `CHK("irq masked", 1'b0, irq)
    wr(ADDR_INT_CLR, 32'h7);
    wr(ADDR_INT_EN, 32'h2);
    repeat (2) @(posedge aclk);
    `CHK("irq cleared", 1'b0, irq)
    // Abort in mid-frame while the data bits hold the line high
    wr(ADDR_TXDATA, 32'hFF);
    repeat (400) @(posedge aclk);
    `CHK("mid frame", 1'b1, pin)
    setc(32'h10);
    repeat (2) @(posedge aclk);
    #1;
    `CHK("break pin", 1'b0, pin)
    rd(ADDR_STAT);
    `CHK("transmit_data_empty_flag abort", 1'b1, rd_data[0])
    `CHK("busy abort", 1'b0, rd_data[6])
    setc(32'h12);
    fork
      line_partner_inst.hold_break(4000);
      begin
        wait_stat(4, 1'b1);
        `CHK("break rxd", 1'b0, rd_data[5])
        wr(ADDR_STAT, 32'h1C);
        rd(ADDR_STAT);
        `CHK("fer cleared", 1'b0, rd_data[4])
        wait_stat(4, 1'b1);
        setc(32'h10);
        rd(ADDR_STAT);
        `CHK("fer kept", 1'b1, rd_data[4])
      end
    join
    // Synchronous mode holds off while an error flag stands
    setc(32'h15);
    wr(ADDR_TXDATA, 32'h5A);
    repeat (300) @(posedge aclk);
    rd(ADDR_STAT);
    `CHK("transmit_data_empty_flag held", 1'b0, rd_data[0])
    `CHK("busy held", 1'b0, rd_data[6])
    wr(ADDR_STAT, 32'h1C);
    wait_stat(0, 1'b1);
    n = 0;
    while (sck_o !== 1'b0 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    `CHK("sck low", 1'b0, sck_o)
    repeat (1000) @(posedge aclk);
    setc(32'h12);
    // The first break frame is still waiting; a break receives as all zeros
    rd(ADDR_RXDATA);
    `CHK("break data", 32'h0, rd_data)
    wr(ADDR_INT_CLR, 32'h7);
    wr(ADDR_INT_EN, 32'h1);
    b = 8'($urandom);
    line_partner_inst.send_byte(b);
    wait_stat(1, 1'b1);
    rd(ADDR_RXDATA);
    `CHK("rx byte", 32'(b), rd_data)
    `CHK("irq rx", 1'b1, irq)
    wr(ADDR_INT_CLR, 32'h1);
    rd(ADDR_INT_STAT);
    `CHK("int stat", 32'h0, rd_data)
    rd(ADDR_CTRL);
    `CHK("ctrl model", 32'(ctrl_m), rd_data)
    test_done();
  end
endmodule : test_serial_port_line_control
